// >>> gpib_pkg.sv
// Shared constants, command codes and helpers for the GPIB interface.
package gpib_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TXD = 8'h08;
  localparam logic [7:0] REG_TXEND = 8'h0c;
  localparam logic [7:0] REG_RXD = 8'h10;
  localparam logic [7:0] REG_STB = 8'h14;
  localparam logic [7:0] REG_EVT = 8'h18;

  // Status register bit positions.
  localparam int ST_LISTEN = 0;
  localparam int ST_TALK = 1;
  localparam int ST_REMOTE = 2;
  localparam int ST_LOCKOUT = 3;
  localparam int ST_TONLY = 4;
  localparam int ST_TXFULL = 5;
  localparam int ST_RXFULL = 6;
  localparam int ST_SPOLL = 7;

  // Event register bit positions; the low three are read-to-clear.
  localparam int EV_NOREM = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_RXEND = 3;
  localparam int EV_SRQLINE = 4;

  // Status byte bit that requests service.
  localparam int STB_RSV = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Address setting.
  localparam logic [5:0] PAD_RESET = 6'h1c;
  localparam logic [5:0] PAD_MAX = 6'h1e;
  localparam logic [5:0] TON_MIN = 6'h28;
  localparam logic [5:0] TON_MAX = 6'h2b;

  // Interface messages carried with attention true (seven bits), and the eight-bit data terminator.
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] LAG_BASE = 7'h20;
  localparam logic [6:0] TAG_BASE = 7'h40;
  localparam logic [7:0] TERM_CHAR = 8'h58;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: data settling before the valid strobe, as a least time.
  localparam int CLK_NS = 100;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] SETTLE_CNT = 5'(SETTLE_CYC);

  function automatic logic pad_ok(logic [5:0] v);
    return (v <= PAD_MAX) || (v >= TON_MIN && v <= TON_MAX);
  endfunction : pad_ok

  function automatic logic addr_match(logic [6:0] cmd, logic [6:0] base,
                                      logic [5:0] pad);
    return (cmd[6:5] == base[6:5]) && (cmd[4:0] == pad[4:0]) &&
           (pad <= PAD_MAX);
  endfunction : addr_match

endpackage : gpib_pkg

// >>> gpib_sync.sv
// Two flip-flop synchroniser for asynchronous bus lines.
`timescale 1ns/1ps
module gpib_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Lines
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Idle bus lines are high, so both stages reset to released.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sync_delay_a: assert property (##2 (q == $past(d, 2)))
    else $error("synchroniser delay is not two cycles");

endmodule : gpib_sync

// >>> gpib_source_hs.sv
// Source handshake: drives data, end and data-valid for each byte sent.
`timescale 1ns/1ps
module gpib_source_hs
  import gpib_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Byte to send
  input wire logic active,
  input wire logic start,
  input wire logic [7:0] byte_in,
  input wire logic eoi_in,
  output logic done_q,
  // Synchronised handshake lines, true level
  input wire logic nrfd_t,
  input wire logic ndac_t,
  // Open-collector enables
  output logic dav_oe_q,
  output logic [7:0] dio_oe_q,
  output logic eoi_oe_q
);

  typedef enum {SH_IDLE, SH_WAIT_RFD, SH_SETTLE, SH_WAIT_DAC, SH_WAIT_NDAC}
    sh_state_t;

  sh_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic dav_d, eoi_d, done_d;
  logic [7:0] dio_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dav_d = dav_oe_q;
    dio_d = dio_oe_q;
    eoi_d = eoi_oe_q;
    done_d = 1'b0;
    case (st_q)
      SH_IDLE: begin
        if (active && start) begin
          dio_d = byte_in;
          eoi_d = eoi_in;
          st_d = SH_WAIT_RFD;
        end
      end
      // All acceptors must be ready and at least one present.
      SH_WAIT_RFD: begin
        if (!nrfd_t && ndac_t) begin
          cnt_d = 5'h00;
          st_d = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == SETTLE_CNT - 5'h01) begin
          dav_d = 1'b1;
          st_d = SH_WAIT_DAC;
        end
      end
      SH_WAIT_DAC: begin
        if (!ndac_t) begin
          dav_d = 1'b0;
          dio_d = 8'h00;
          eoi_d = 1'b0;
          done_d = 1'b1;
          st_d = SH_WAIT_NDAC;
        end
      end
      // Waiting for accepted to drop stops one byte counting twice.
      SH_WAIT_NDAC: begin
        if (ndac_t) begin
          st_d = SH_IDLE;
        end
      end
      default: begin
        st_d = SH_IDLE;
      end
    endcase
    // Attention from the controller takes the bus back at once.
    if (!active) begin
      st_d = SH_IDLE;
      dav_d = 1'b0;
      dio_d = 8'h00;
      eoi_d = 1'b0;
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SH_IDLE;
      cnt_q <= 5'h00;
      dav_oe_q <= 1'b0;
      dio_oe_q <= 8'h00;
      eoi_oe_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dav_oe_q <= dav_d;
      dio_oe_q <= dio_d;
      eoi_oe_q <= eoi_d;
      done_q <= done_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  dav_settle_a: assert property ($rose(dav_oe_q) |->
      $past(st_q == SH_SETTLE && cnt_q == SETTLE_CNT - 5'h01))
    else $error("data valid asserted before settling time");

  dav_hold_a: assert property (dav_oe_q && ndac_t && active |=>
      dav_oe_q && $stable(dio_oe_q))
    else $error("data valid or data dropped before acceptance");

endmodule : gpib_source_hs

// >>> gpib_instrument_interface.sv
// Instrument-side GPIB interface: addressing, handshakes and bus commands.
`timescale 1ns/1ps
module gpib_instrument_interface
  import gpib_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Bus data lines
  input wire logic [7:0] DIO_I,
  output logic [7:0] DIO_O,
  output logic [7:0] DIO_OE,
  // Bus handshake lines
  input wire logic DAV_I,
  output logic DAV_O,
  output logic DAV_OE,
  input wire logic NRFD_I,
  output logic NRFD_O,
  output logic NRFD_OE,
  input wire logic NDAC_I,
  output logic NDAC_O,
  output logic NDAC_OE,
  // Bus management lines
  input wire logic EOI_I,
  output logic EOI_O,
  output logic EOI_OE,
  input wire logic SRQ_I,
  output logic SRQ_O,
  output logic SRQ_OE,
  input wire logic ATN_I,
  input wire logic IFC_I,
  input wire logic REN_I,
  // Instrument side
  output logic PANEL_LOCK,
  output logic REMOTE,
  output logic DEV_CLEAR,
  output logic TRIGGER
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised bus lines; a low line is a true message.
  logic [15:0] pins_s;
  logic [7:0] dio_t;
  logic srq_t, ren_t, ifc_t, atn_t, eoi_t, ndac_t, nrfd_t, dav_t;

  gpib_sync #(.W(16)) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .d({SRQ_I, REN_I, IFC_I, ATN_I, EOI_I, NDAC_I, NRFD_I, DAV_I, DIO_I}),
    .q(pins_s)
  );

  assign {srq_t, ren_t, ifc_t, atn_t, eoi_t, ndac_t, nrfd_t, dav_t, dio_t} =
    ~pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Interface state declarations.
  logic listen_q, listen_d, talk_q, talk_d, spoll_q, spoll_d;
  logic remote_q, remote_d, lockout_q, lockout_d;
  logic [5:0] pad_q, pad_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, stb_q, stb_d, rdata_q, rd_d;
  logic tx_end_q, tx_end_d, tx_full_q, tx_full_d;
  logic rx_end_q, rx_end_d, rx_full_q, rx_full_d;
  logic [2:0] evt_q, evt_d;
  logic clear_q, clear_d, trig_q, trig_d, lock_q, srq_oe_q, drv_lvl_q;
  logic ton, talk_act, sp_act, sh_done, ah_take, dev_clr;
  logic [6:0] cmd;

  // Talk-only runs the talker with no controller; attention is never driven.
  assign ton = (pad_q >= TON_MIN);
  assign talk_act = talk_q || ton;
  assign sp_act = spoll_q && talk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptor handshake.
  typedef enum {AH_IDLE, AH_NRDY, AH_READY, AH_ACCEPT} ah_state_t;

  ah_state_t ah_q, ah_d;
  logic nrfd_oe_q, nrfd_oe_d, ndac_oe_q, ndac_oe_d, acc_act, buf_ok;

  // Commands are always taken; data only by a listener with room.
  assign acc_act = atn_t || listen_q;
  assign buf_ok = atn_t || !rx_full_q;
  assign ah_take = (ah_q == AH_READY) && acc_act && dav_t;

  always_comb begin
    ah_d = ah_q;
    nrfd_oe_d = nrfd_oe_q;
    ndac_oe_d = ndac_oe_q;
    case (ah_q)
      AH_IDLE: begin
        nrfd_oe_d = 1'b0;
        ndac_oe_d = 1'b0;
        if (acc_act) begin
          nrfd_oe_d = 1'b1;
          ndac_oe_d = 1'b1;
          ah_d = AH_NRDY;
        end
      end
      AH_NRDY: begin
        if (buf_ok && !dav_t) begin
          nrfd_oe_d = 1'b0;
          ah_d = AH_READY;
        end
      end
      AH_READY: begin
        if (ah_take) begin
          nrfd_oe_d = 1'b1;
          ndac_oe_d = 1'b0;
          ah_d = AH_ACCEPT;
        end
      end
      AH_ACCEPT: begin
        if (!dav_t) begin
          ndac_oe_d = 1'b1;
          ah_d = AH_NRDY;
        end
      end
      default: begin
        ah_d = AH_IDLE;
      end
    endcase
    if (!acc_act && ah_q != AH_ACCEPT) begin
      ah_d = AH_IDLE;
      nrfd_oe_d = 1'b0;
      ndac_oe_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ah_q <= AH_IDLE;
      nrfd_oe_q <= 1'b0;
      ndac_oe_q <= 1'b0;
    end else begin
      ah_q <= ah_d;
      nrfd_oe_q <= nrfd_oe_d;
      ndac_oe_q <= ndac_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source handshake; the status byte replaces data during serial poll.
  gpib_source_hs u_src (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .active(talk_act && !atn_t),
    .start(sp_act || tx_full_q),
    .byte_in(sp_act ? stb_q : tx_q),
    .eoi_in(!sp_act && tx_end_q),
    .done_q(sh_done),
    .nrfd_t(nrfd_t),
    .ndac_t(ndac_t),
    .dav_oe_q(DAV_OE),
    .dio_oe_q(DIO_OE),
    .eoi_oe_q(EOI_OE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Addressing, bus commands and registers. Clears come before sets so a
  // flag raised in the cycle it is cleared survives.
  always_comb begin
    listen_d = listen_q;
    talk_d = talk_q;
    spoll_d = spoll_q;
    remote_d = remote_q;
    lockout_d = lockout_q;
    pad_d = pad_q;
    tx_d = tx_q;
    tx_end_d = tx_end_q;
    tx_full_d = tx_full_q;
    rx_d = rx_q;
    rx_end_d = rx_end_q;
    rx_full_d = rx_full_q;
    stb_d = stb_q;
    evt_d = evt_q;
    clear_d = 1'b0;
    trig_d = 1'b0;
    dev_clr = 1'b0;
    rd_d = 8'h00;
    cmd = dio_t[6:0];
    if (!ren_t) begin
      remote_d = 1'b0;
      lockout_d = 1'b0;
    end
    if (ifc_t) begin
      listen_d = 1'b0;
      talk_d = 1'b0;
      spoll_d = 1'b0;
    end
    if (RD) begin
      case (ADDR)
        REG_CFG: rd_d = {2'b00, pad_q};
        REG_STAT: rd_d = {spoll_q, rx_full_q, tx_full_q, ton, lockout_q,
                          remote_q, talk_q, listen_q};
        REG_RXD: begin
          rd_d = rx_q;
          rx_full_d = 1'b0;
        end
        REG_STB: rd_d = stb_q;
        REG_EVT: begin
          rd_d = {3'b000, srq_t, rx_end_q, evt_q};
          evt_d = 3'b000;
        end
        default: rd_d = 8'h00;
      endcase
    end
    if (sh_done) begin
      if (sp_act) begin
        stb_d[STB_RSV] = 1'b0;
      end else begin
        tx_full_d = 1'b0;
      end
    end
    // Parallel poll and secondary addresses fall through untouched.
    if (ah_take && atn_t) begin
      if (addr_match(cmd, LAG_BASE, pad_q) && !ton) begin
        listen_d = 1'b1;
        talk_d = 1'b0;
        if (ren_t) begin
          remote_d = 1'b1;
        end
      end else if (cmd == CMD_UNL) begin
        listen_d = 1'b0;
      end else if (addr_match(cmd, TAG_BASE, pad_q) && !ton) begin
        talk_d = 1'b1;
        listen_d = 1'b0;
      end else if (cmd[6:5] == TAG_BASE[6:5]) begin
        talk_d = 1'b0;
      end else if (cmd == CMD_LLO) begin
        lockout_d = ren_t;
      end else if (cmd == CMD_DCL || (cmd == CMD_SDC && listen_q)) begin
        dev_clr = 1'b1;
      end else if (cmd == CMD_GET && listen_q) begin
        trig_d = 1'b1;
        evt_d[EV_TRIG] = 1'b1;
      end else if (cmd == CMD_GTL && listen_q) begin
        remote_d = 1'b0;
      end else if (cmd == CMD_SPE) begin
        spoll_d = 1'b1;
      end else if (cmd == CMD_SPD) begin
        spoll_d = 1'b0;
      end
    end else if (ah_take && listen_q) begin
      rx_d = dio_t;
      rx_end_d = eoi_t;
      rx_full_d = 1'b1;
      if (dio_t == TERM_CHAR && !ren_t) begin
        evt_d[EV_NOREM] = 1'b1;
      end
    end
    if (dev_clr) begin
      tx_full_d = 1'b0;
      rx_full_d = 1'b0;
      stb_d = 8'h00;
      clear_d = 1'b1;
      evt_d[EV_CLEAR] = 1'b1;
    end
    if (WR) begin
      case (ADDR)
        REG_CFG: begin
          if (pad_ok(WDATA[5:0]) && WDATA[7:6] == 2'b00) begin
            pad_d = WDATA[5:0];
          end
        end
        REG_TXD, REG_TXEND: begin
          // A byte written while one is pending is dropped.
          if (!tx_full_q) begin
            tx_d = WDATA;
            tx_end_d = (ADDR == REG_TXEND);
            tx_full_d = 1'b1;
          end
        end
        REG_STB: stb_d = WDATA;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      spoll_q <= 1'b0;
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
      pad_q <= PAD_RESET;
      tx_q <= 8'h00;
      tx_end_q <= 1'b0;
      tx_full_q <= 1'b0;
      rx_q <= 8'h00;
      rx_end_q <= 1'b0;
      rx_full_q <= 1'b0;
      stb_q <= 8'h00;
      evt_q <= 3'b000;
      clear_q <= 1'b0;
      trig_q <= 1'b0;
      rdata_q <= 8'h00;
      lock_q <= 1'b0;
      srq_oe_q <= 1'b0;
      drv_lvl_q <= 1'b0;
    end else begin
      listen_q <= listen_d;
      talk_q <= talk_d;
      spoll_q <= spoll_d;
      remote_q <= remote_d;
      lockout_q <= lockout_d;
      pad_q <= pad_d;
      tx_q <= tx_d;
      tx_end_q <= tx_end_d;
      tx_full_q <= tx_full_d;
      rx_q <= rx_d;
      rx_end_q <= rx_end_d;
      rx_full_q <= rx_full_d;
      stb_q <= stb_d;
      evt_q <= evt_d;
      clear_q <= clear_d;
      trig_q <= trig_d;
      rdata_q <= rd_d;
      lock_q <= remote_d && lockout_d;
      srq_oe_q <= stb_d[STB_RSV] && !(spoll_d && talk_d);
      drv_lvl_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-collector outputs only ever pull low.
  assign DIO_O = {8{drv_lvl_q}};
  assign DAV_O = drv_lvl_q;
  assign NRFD_O = drv_lvl_q;
  assign NDAC_O = drv_lvl_q;
  assign EOI_O = drv_lvl_q;
  assign SRQ_O = drv_lvl_q;
  assign NRFD_OE = nrfd_oe_q;
  assign NDAC_OE = ndac_oe_q;
  assign SRQ_OE = srq_oe_q;
  assign RDATA = rdata_q;
  assign PANEL_LOCK = lock_q;
  assign REMOTE = remote_q;
  assign DEV_CLEAR = clear_q;
  assign TRIGGER = trig_q;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  rx_listen_a: assert property ($rose(rx_full_q) |-> $past(listen_q))
    else $error("data byte stored while not listener");

  talk_gate_a: assert property ($rose(DAV_OE) |->
      $past(talk_act, 1) && $past(talk_act, 2))
    else $error("data sourced while not talker");

  pad_range_a: assert property (pad_ok(pad_q))
    else $error("address setting out of range");

  remote_seq_a: assert property ($rose(remote_q) |->
      $past(ren_t && listen_d && ah_take))
    else $error("remote entered without enable and listen address");

  lockout_a: assert property (remote_q && lockout_q |-> PANEL_LOCK)
    else $error("panel not locked in remote with lockout");

  noremote_a: assert property (ah_take && !atn_t && listen_q &&
      dio_t == TERM_CHAR && !ren_t && !(RD && ADDR == REG_EVT) |=>
      evt_q[EV_NOREM])
    else $error("no-remote error not flagged on terminator");

  srq_a: assert property (stb_q[STB_RSV] && !sp_act &&
      !(RD || WR || dev_clr) |=> SRQ_OE || sp_act)
    else $error("service request not asserted");

  trig_a: assert property (ah_take && atn_t && listen_q &&
      cmd == CMD_GET |=> TRIGGER ##1 !TRIGGER)
    else $error("trigger pulse missing after group trigger");

  clear_a: assert property (ah_take && atn_t && cmd == CMD_DCL &&
      !WR |=> DEV_CLEAR && !rx_full_q && !stb_q[STB_RSV])
    else $error("device clear not applied");

  accept_a: assert property (ah_take |=> NRFD_OE && !NDAC_OE ##1
      NRFD_OE)
    else $error("acceptor did not hold off after taking byte");

endmodule : gpib_instrument_interface

// >>> gpib_ctl_model.sv
// Bus controller model: sources commands and data, accepts talker bytes.
`timescale 1ns/1ps
module gpib_ctl_model (
  // Clock
  input wire logic clk,
  // Own drive levels, low pulls the wire
  output logic atn_b,
  output logic dav_b,
  output logic nrfd_b,
  output logic ndac_b,
  output logic [7:0] dio_b,
  // Wire levels
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic [7:0] dio_w
);

  initial begin
    {atn_b, dav_b, nrfd_b, ndac_b, dio_b} = '1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released data lines float to the pull-up, never the last byte.
  task automatic send(input logic [7:0] b, input logic atn);
    int i;
    @(posedge clk);
    atn_b <= ~atn;
    dio_b <= ~b;
    // Acceptors need a few cycles to see attention and answer it.
    repeat (4) @(posedge clk);
    for (i = 0; i < 300 && !(nrfd_w && !ndac_w); i++) @(posedge clk);
    dav_b <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 300 && !ndac_w; i++) @(posedge clk);
    dav_b <= 1'b1;
    dio_b <= 8'hff;
    repeat (4) @(posedge clk);
  endtask : send

  task automatic atn_off;
    @(posedge clk);
    atn_b <= 1'b1;
  endtask : atn_off

  // A slow acceptor holds not-ready for a while to stall the talker.
  task automatic recv(output logic [7:0] b, input int slow);
    int i;
    @(posedge clk);
    ndac_b <= 1'b0;
    if (slow > 0) begin
      nrfd_b <= 1'b0;
      repeat (slow) @(posedge clk);
    end
    nrfd_b <= 1'b1;
    for (i = 0; i < 300 && dav_w; i++) @(posedge clk);
    b = ~dio_w;
    nrfd_b <= 1'b0;
    ndac_b <= 1'b1;
    for (i = 0; i < 300 && !dav_w; i++) @(posedge clk);
    nrfd_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : recv

endmodule : gpib_ctl_model

// >>> tb_gpib_instrument_interface.sv
// Self-checking bench for the instrument interface with a controller model.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("unexpected %s expected %0h seen %0h", n, e, g); \
    end \
  end
module tb_gpib_instrument_interface;
  import gpib_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ren_b = 1'b1;
  logic ifc_b = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata, dio_oe, dio_b, dio_w;
  logic atn_b, dav_b, nrfd_b, ndac_b, dav_w, nrfd_w, ndac_w;
  logic dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, lock, remote, clr, trg;
  int n_errors = 0;
  int check_count = 0;
  int n_clr = 0;
  int n_trg = 0;
  byte unsigned txq[$];
  byte unsigned rxq[$];

  always #50 clk = ~clk;
  assign dav_w = dav_b & ~dav_oe;
  assign nrfd_w = nrfd_b & ~nrfd_oe;
  assign ndac_w = ndac_b & ~ndac_oe;
  assign dio_w = dio_b & ~dio_oe;

  gpib_ctl_model ctl (.clk(clk), .atn_b(atn_b), .dav_b(dav_b),
    .nrfd_b(nrfd_b), .ndac_b(ndac_b), .dio_b(dio_b), .dav_w(dav_w),
    .nrfd_w(nrfd_w), .ndac_w(ndac_w), .dio_w(dio_w));

  gpib_instrument_interface uut (.REF_CLK(clk), .RST_B(rst_b),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DIO_I(dio_w), .DIO_O(), .DIO_OE(dio_oe), .DAV_I(dav_w), .DAV_O(),
    .DAV_OE(dav_oe), .NRFD_I(nrfd_w), .NRFD_O(), .NRFD_OE(nrfd_oe),
    .NDAC_I(ndac_w), .NDAC_O(), .NDAC_OE(ndac_oe), .EOI_I(~eoi_oe),
    .EOI_O(), .EOI_OE(eoi_oe), .SRQ_I(~srq_oe), .SRQ_O(),
    .SRQ_OE(srq_oe), .ATN_I(atn_b), .IFC_I(ifc_b), .REN_I(ren_b),
    .PANEL_LOCK(lock), .REMOTE(remote), .DEV_CLEAR(clr), .TRIGGER(trg));

  always @(posedge clk) begin
    if (clr === 1'b1) n_clr++;
    if (trg === 1'b1) n_trg++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [5:0] p;
    void'($urandom(32'h5e8b));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(REG_CFG, d);
    `CHK("cfg", PAD_RESET, d[5:0]);
    rd_reg(8'h1c, d);
    `CHK("unmapped", 8'h00, d);
    for (int k = 0; k < 4; k++) begin
      // The controller model answers to no address, so p stays unique.
      p = 6'($urandom_range(30));
      wr_reg(REG_CFG, {2'b00, p});
      rd_reg(REG_CFG, d);
      `CHK("cfg", p, d[5:0]);
    end
    wr_reg(REG_CFG, 8'h1f);
    rd_reg(REG_CFG, d);
    `CHK("cfg", p, d[5:0]);
    // Data and secondary addresses before listen addressing are ignored.
    ctl.send(8'ha5, 1'b0);
    ctl.send({2'b01, 1'b1, p[4:0]}, 1'b1);
    rd_reg(REG_STAT, d);
    `CHK("stat", 8'h00, d);
    ren_b <= 1'b0;
    ctl.send({3'b001, p[4:0]}, 1'b1);
    rd_reg(REG_STAT, d);
    `CHK("listen", 1'b1, d[ST_LISTEN]);
    `CHK("remote", 1'b1, remote);
    rxq.push_back(8'($urandom_range(8'h57)));
    ctl.send(rxq[0], 1'b0);
    rd_reg(REG_RXD, d);
    e = rxq.pop_front();
    `CHK("rxd", e, d);
    ctl.send({1'b0, CMD_LLO}, 1'b1);
    `CHK("lock", 1'b1, lock);
    ctl.send({1'b0, CMD_GET}, 1'b1);
    `CHK("trig", 1, n_trg);
    ctl.send({1'b0, CMD_SDC}, 1'b1);
    ctl.send({1'b0, CMD_DCL}, 1'b1);
    `CHK("clear", 2, n_clr);
    ctl.send({1'b0, CMD_GTL}, 1'b1);
    `CHK("remote", 1'b0, remote);
    ren_b <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("lock", 1'b0, lock);
    rd_reg(REG_STAT, d);
    `CHK("lockout", 1'b0, d[ST_LOCKOUT]);
    ctl.send(TERM_CHAR, 1'b0);
    rd_reg(REG_EVT, d);
    `CHK("noremote", 1'b1, d[EV_NOREM]);
    // Serial poll first, then the queued byte with a stalling acceptor.
    wr_reg(REG_TXD, 8'h55);
    txq.push_back(8'h55);
    repeat (40) @(posedge clk);
    `CHK("dav", 1'b0, dav_oe);
    wr_reg(REG_STB, 8'h41);
    repeat (4) @(posedge clk);
    `CHK("srq", 1'b1, srq_oe);
    ctl.send({1'b0, CMD_SPE}, 1'b1);
    ctl.send({2'b10, p[4:0]}, 1'b1);
    ctl.atn_off();
    ctl.recv(d, 3);
    `CHK("stb", 8'h41, d);
    `CHK("srq", 1'b0, srq_oe);
    ctl.send({1'b0, CMD_SPD}, 1'b1);
    ctl.atn_off();
    ctl.recv(d, 30);
    e = txq.pop_front();
    `CHK("txd", e, d);
    ctl.send(8'h5f, 1'b1);
    rd_reg(REG_STAT, d);
    `CHK("stat", 8'h00, d & 8'h03);
    // Interface clear drops a fresh listen address at once.
    ctl.send({3'b001, p[4:0]}, 1'b1);
    ifc_b <= 1'b0;
    repeat (4) @(posedge clk);
    ifc_b <= 1'b1;
    rd_reg(REG_STAT, d);
    `CHK("ifc", 8'h00, d & 8'h03);
    ctl.atn_off();
    // Talk-only runs with the controller silent.
    wr_reg(REG_CFG, 8'h28 + 8'($urandom_range(3)));
    wr_reg(REG_TXEND, 8'hc3);
    ctl.recv(d, 0);
    `CHK("tonly", 8'hc3, d);
    `CHK("pp", 8'h00, dio_oe);
    complete_run();
  end

endmodule : tb_gpib_instrument_interface
